// ### rtl/clock_distribution_config_regs.svh
// register indices, fields, reset values and codes of the clock distribution bank
`ifndef CLOCK_DISTRIBUTION_CONFIG_REGS_SVH
`define CLOCK_DISTRIBUTION_CONFIG_REGS_SVH
`define CDC_IDX_SYNC_MASK   12'h500
`define CDC_IDX_CH0_LOW     12'h502
`define CDC_IDX_CH0_CTRL    12'h503
`define CDC_IDX_CH0_PHASE   12'h504
`define CDC_IDX_OUT_TWO     12'h505
`define CDC_IDX_SPARE       12'h506
`define CDC_IDX_CH1_LOW     12'h507
`define CDC_IDX_CH1_CTRL    12'h508
`define CDC_IDX_CH1_PHASE   12'h509
`define CDC_IDX_REF_POWER   12'h600
`define CDC_IDX_REF_FAMILY  12'h601
`define CDC_SLOT_SYNC_MASK  4'h0
`define CDC_SLOT_CH0_LOW    4'h1
`define CDC_SLOT_CH0_CTRL   4'h2
`define CDC_SLOT_CH0_PHASE  4'h3
`define CDC_SLOT_OUT_TWO    4'h4
`define CDC_SLOT_CH1_LOW    4'h5
`define CDC_SLOT_CH1_CTRL   4'h6
`define CDC_SLOT_CH1_PHASE  4'h7
`define CDC_SLOT_REF_POWER  4'h8
`define CDC_SLOT_REF_FAMILY 4'h9
`define CDC_NUM_SLOTS       10
`define CDC_CH_BASE         1
`define CDC_CH_STRIDE       4
`define CDC_WMASK_SYNC_MASK 8'h30
`define CDC_WMASK_LOW       8'hFF
`define CDC_WMASK_CTRL      8'h0F
`define CDC_WMASK_PHASE     8'h3F
`define CDC_WMASK_OUT_TWO   8'h7F
`define CDC_WMASK_REF_POWER 8'h03
`define CDC_WMASK_REF_FAM   8'h0F
`define CDC_RST_OUT_TWO     8'h10
`define CDC_RST_ZERO        8'h00
`define CDC_MASK_LSB        4
`define CDC_CTRL_OFF_BIT    3
`define CDC_CTRL_PRESEL_BIT 2
`define CDC_CTRL_HI_MSB     1
`define CDC_PHASE_MSB       5
`define CDC_FMT_MSB         6
`define CDC_FMT_LSB         4
`define CDC_POL_P_BIT       3
`define CDC_POL_N_BIT       2
`define CDC_DRIVE_BIT       1
`define CDC_EN_BIT          0
`define CDC_FMT_OFF         3'h0
`define CDC_FMT_HSTL        3'h1
`define CDC_FMT_LVDS        3'h2
`define CDC_FMT_CMOS_BOTH   3'h4
`define CDC_FMT_CMOS_P      3'h5
`define CDC_FMT_CMOS_N      3'h6
`define CDC_FAM_DIFF        2'h0
`define CDC_ADR_IDX_MSB     13
`define CDC_ADR_IDX_LSB     2
`define CDC_ADR_HI_LSB      14
`endif

// ### rtl/clock_distribution_config_pkg.sv
// types shared by the clock distribution bank
package clock_distribution_config_pkg;
  typedef enum logic [2:0] {
    CH_HOLD = 3'h1,
    CH_RUN  = 3'h2,
    CH_OFF  = 3'h4
  } chan_state_e;
  typedef logic [7:0] cfg_byte_t;
endpackage : clock_distribution_config_pkg

// ### rtl/clock_distribution_config.sv
// clock distribution and reference receiver configuration bank with wishbone slave
`include "clock_distribution_config_regs.svh"
// Functional notes
// - each channel divides its input by the 10-bit field plus one, 0 giving 1 and 1023 giving 1024.
// - channel zero's divide value is the low byte register joined with bits 1:0 of the next one.
// - a channel's power-off bit stops that channel, and zero keeps it running.
// - the prescaler select bit picks the second prescaling divider when set, else the first.
// - after a sync the divider starts at a phase counted in half input periods (prescaler ticks), zero meaning none.
// - the second output's 3-bit format picks tristate, HSTL, LVDS or one of three CMOS modes.
// - the second output's polarity sets each leg's sense and only acts in CMOS formats.
// - the drive bit selects LVDS boost when set and nominal drive when clear.
// - the second output drives only while its enable bit is one, which resets to zero.
// - channel one has the same divide, power-off, prescaler and phase controls in three registers.
// - each reference receiver has its own power-off bit, bit 1 second and bit 0 first.
// - with every reference power-off bit set the receiver section goes into deep sleep.
// - the second reference's 2-bit family picks differential or one of three CMOS ranges.
// - in a CMOS family a receiver uses only its positive pin and ignores the other one.
// - the first reference's family sits in bits 1:0 with the same codes.
// - unless its sync mask is set a channel stays held with its output still until a sync pulse.
module clock_distribution_config (
  input  wire logic        core_clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic             wb_ack_o,
  output logic      [31:0] wb_dat_o,
  input  wire logic        first_prescaling_divider_tick_i,
  input  wire logic        second_prescaling_divider_tick_i,
  input  wire logic        sync_pulse_i,
  output logic      [1:0]  chan_clk_o,
  output logic      [1:0]  chan_power_off_o,
  output logic             second_output_pair_p_o,
  output logic             second_output_pair_n_o,
  output logic             second_output_pair_p_oe_b_o,
  output logic             second_output_pair_n_oe_b_o,
  output logic             second_output_pair_boost_o,
  output logic      [2:0]  second_output_pair_format_o,
  input  wire logic        first_reference_input_p_i,
  input  wire logic        first_reference_input_n_i,
  input  wire logic        second_reference_input_p_i,
  input  wire logic        second_reference_input_n_i,
  output logic             first_reference_input_o,
  output logic             second_reference_input_o,
  output logic      [1:0]  ref_power_off_o,
  output logic             ref_deep_sleep_o,
  output logic      [3:0]  ref_family_o
);

  clock_distribution_config_pkg::cfg_byte_t reg_q [`CDC_NUM_SLOTS];
  logic                                      ack_q;
  logic [31:0]                               dat_q;
  logic [4:0]                                hit;
  logic                                      wr_en;
  clock_distribution_config_pkg::chan_state_e ch_state_q [2];
  logic [9:0]                                cnt_q [2];
  logic [9:0]                                div_val [2];
  logic [5:0]                                ph_val [2];
  logic [1:0]                                ch_off;
  logic [1:0]                                ch_mask;
  logic [1:0]                                ch_tick;
  logic [1:0]                                chan_clk_q;
  logic [2:0]                                out_fmt;
  logic [3:0]                                pin_in;
  logic [2:0]                                sync_q [4];
  logic [3:0]                                filt_q;
  logic [1:0]                                ref_out_q;
  logic                                      deep_q;
  logic                                      p_q;
  logic                                      n_q;
  logic                                      p_oe_b_q;
  logic                                      n_oe_b_q;
  logic                                      boost_q;
  logic [2:0]                                fmt_q;

  // index decode: bit 4 marks a mapped register, bits 3:0 its slot
  function automatic logic [4:0] slot_of(input logic [31:0] adr);
    logic [11:0] idx;
    logic [4:0]  r;
    idx = adr[`CDC_ADR_IDX_MSB:`CDC_ADR_IDX_LSB];
    r   = 5'h00;
    if (adr[31:`CDC_ADR_HI_LSB] == '0) begin
      case (idx)
        `CDC_IDX_SYNC_MASK:  r = {1'b1, `CDC_SLOT_SYNC_MASK};
        `CDC_IDX_CH0_LOW:    r = {1'b1, `CDC_SLOT_CH0_LOW};
        `CDC_IDX_CH0_CTRL:   r = {1'b1, `CDC_SLOT_CH0_CTRL};
        `CDC_IDX_CH0_PHASE:  r = {1'b1, `CDC_SLOT_CH0_PHASE};
        `CDC_IDX_OUT_TWO:    r = {1'b1, `CDC_SLOT_OUT_TWO};
        `CDC_IDX_CH1_LOW:    r = {1'b1, `CDC_SLOT_CH1_LOW};
        `CDC_IDX_CH1_CTRL:   r = {1'b1, `CDC_SLOT_CH1_CTRL};
        `CDC_IDX_CH1_PHASE:  r = {1'b1, `CDC_SLOT_CH1_PHASE};
        `CDC_IDX_REF_POWER:  r = {1'b1, `CDC_SLOT_REF_POWER};
        `CDC_IDX_REF_FAMILY: r = {1'b1, `CDC_SLOT_REF_FAMILY};
        default:             r = 5'h00;
      endcase
    end
    return r;
  endfunction : slot_of

  function automatic logic [7:0] wmask_of(input logic [3:0] slot);
    case (slot)
      `CDC_SLOT_SYNC_MASK:  return `CDC_WMASK_SYNC_MASK;
      `CDC_SLOT_CH0_LOW:    return `CDC_WMASK_LOW;
      `CDC_SLOT_CH1_LOW:    return `CDC_WMASK_LOW;
      `CDC_SLOT_CH0_CTRL:   return `CDC_WMASK_CTRL;
      `CDC_SLOT_CH1_CTRL:   return `CDC_WMASK_CTRL;
      `CDC_SLOT_CH0_PHASE:  return `CDC_WMASK_PHASE;
      `CDC_SLOT_CH1_PHASE:  return `CDC_WMASK_PHASE;
      `CDC_SLOT_OUT_TWO:    return `CDC_WMASK_OUT_TWO;
      `CDC_SLOT_REF_POWER:  return `CDC_WMASK_REF_POWER;
      `CDC_SLOT_REF_FAMILY: return `CDC_WMASK_REF_FAM;
      default:              return 8'h00;
    endcase
  endfunction : wmask_of

  function automatic logic is_cmos(input logic [2:0] fmt);
    return (fmt == `CDC_FMT_CMOS_BOTH) || (fmt == `CDC_FMT_CMOS_P) || (fmt == `CDC_FMT_CMOS_N);
  endfunction : is_cmos

  assign hit   = slot_of(wb_adr_i);
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0] && hit[4];

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q && hit[4]) begin
        dat_q <= {24'h00_0000, reg_q[hit[3:0]]};
      end else begin
        dat_q <= 32'h0000_0000;
      end
    end
  end

  // register storage, only writable bits kept
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int s = 0; s < `CDC_NUM_SLOTS; s++) begin
        reg_q[s] <= `CDC_RST_ZERO;
      end
      reg_q[`CDC_SLOT_OUT_TWO] <= `CDC_RST_OUT_TWO;
    end else if (wr_en) begin
      reg_q[hit[3:0]] <= wb_dat_i[7:0] & wmask_of(hit[3:0]);
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  // channel dividers, both from the same three-register layout
  for (genvar c = 0; c < 2; c++) begin : g_chan
    localparam int B = `CDC_CH_BASE + c * `CDC_CH_STRIDE;
    logic [10:0] modv;
    logic [10:0] ph_rem;
    logic [10:0] ph_quo;
    assign div_val[c] = {reg_q[B + 1][`CDC_CTRL_HI_MSB:0], reg_q[B]};
    assign ph_val[c]  = reg_q[B + 2][`CDC_PHASE_MSB:0];
    assign ch_off[c]  = reg_q[B + 1][`CDC_CTRL_OFF_BIT];
    assign ch_mask[c] = reg_q[`CDC_SLOT_SYNC_MASK][`CDC_MASK_LSB + c];
    assign ch_tick[c] = reg_q[B + 1][`CDC_CTRL_PRESEL_BIT] ? second_prescaling_divider_tick_i
                                                           : first_prescaling_divider_tick_i;
    assign modv   = {1'b0, div_val[c]} + 11'h001;
    assign ph_rem = {5'h00, ph_val[c]} % modv;
    assign ph_quo = {5'h00, ph_val[c]} / modv;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        ch_state_q[c] <= clock_distribution_config_pkg::CH_HOLD;
        cnt_q[c]      <= 10'h000;
        chan_clk_q[c] <= 1'b0;
      end else begin
        case (ch_state_q[c])
          clock_distribution_config_pkg::CH_HOLD: begin
            chan_clk_q[c] <= 1'b0;
            if (ch_off[c]) begin
              ch_state_q[c] <= clock_distribution_config_pkg::CH_OFF;
            end else if (ch_mask[c]) begin
              ch_state_q[c] <= clock_distribution_config_pkg::CH_RUN;
              cnt_q[c]      <= 10'h000;
            end else if (sync_pulse_i) begin
              ch_state_q[c] <= clock_distribution_config_pkg::CH_RUN;
              cnt_q[c]      <= ph_rem[9:0];
              chan_clk_q[c] <= ph_quo[0];
            end
          end
          clock_distribution_config_pkg::CH_RUN: begin
            if (ch_off[c]) begin
              ch_state_q[c] <= clock_distribution_config_pkg::CH_OFF;
              chan_clk_q[c] <= 1'b0;
            end else if (sync_pulse_i && !ch_mask[c]) begin
              cnt_q[c]      <= ph_rem[9:0];
              chan_clk_q[c] <= ph_quo[0];
            end else if (ch_tick[c]) begin
              if (cnt_q[c] >= div_val[c]) begin
                cnt_q[c]      <= 10'h000;
                chan_clk_q[c] <= !chan_clk_q[c];
              end else begin
                cnt_q[c] <= cnt_q[c] + 10'h001;
              end
            end
          end
          clock_distribution_config_pkg::CH_OFF: begin
            chan_clk_q[c] <= 1'b0;
            cnt_q[c]      <= 10'h000;
            if (!ch_off[c]) begin
              ch_state_q[c] <= clock_distribution_config_pkg::CH_HOLD;
            end
          end
          default: begin
            ch_state_q[c] <= clock_distribution_config_pkg::CH_HOLD;
          end
        endcase
      end
    end
  end

  assign chan_clk_o       = chan_clk_q;
  assign chan_power_off_o = {reg_q[`CDC_SLOT_CH1_CTRL][`CDC_CTRL_OFF_BIT],
                             reg_q[`CDC_SLOT_CH0_CTRL][`CDC_CTRL_OFF_BIT]};

  // second output driver fed by channel one
  assign out_fmt = reg_q[`CDC_SLOT_OUT_TWO][`CDC_FMT_MSB:`CDC_FMT_LSB];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      p_q      <= 1'b0;
      n_q      <= 1'b0;
      p_oe_b_q <= 1'b1;
      n_oe_b_q <= 1'b1;
      boost_q  <= 1'b0;
      fmt_q    <= `CDC_FMT_HSTL;
    end else begin
      fmt_q    <= out_fmt;
      boost_q  <= reg_q[`CDC_SLOT_OUT_TWO][`CDC_DRIVE_BIT];
      p_q      <= 1'b0;
      n_q      <= 1'b0;
      p_oe_b_q <= 1'b1;
      n_oe_b_q <= 1'b1;
      if (reg_q[`CDC_SLOT_OUT_TWO][`CDC_EN_BIT]) begin
        if ((out_fmt == `CDC_FMT_HSTL) || (out_fmt == `CDC_FMT_LVDS)) begin
          p_q      <= chan_clk_q[1];
          n_q      <= !chan_clk_q[1];
          p_oe_b_q <= 1'b0;
          n_oe_b_q <= 1'b0;
        end else if (is_cmos(out_fmt)) begin
          p_q <= chan_clk_q[1] ^ reg_q[`CDC_SLOT_OUT_TWO][`CDC_POL_P_BIT];
          n_q <= chan_clk_q[1] ^ !(reg_q[`CDC_SLOT_OUT_TWO][`CDC_POL_P_BIT]
                                   ^ reg_q[`CDC_SLOT_OUT_TWO][`CDC_POL_N_BIT]);
          p_oe_b_q <= (out_fmt == `CDC_FMT_CMOS_N);
          n_oe_b_q <= (out_fmt == `CDC_FMT_CMOS_P);
        end
      end
    end
  end

  assign second_output_pair_p_o      = p_q;
  assign second_output_pair_n_o      = n_q;
  assign second_output_pair_p_oe_b_o = p_oe_b_q;
  assign second_output_pair_n_oe_b_o = n_oe_b_q;
  assign second_output_pair_boost_o  = boost_q;
  assign second_output_pair_format_o = fmt_q;

  // reference pins: three-stage synchroniser, change taken when stages two and three agree
  assign pin_in = {second_reference_input_n_i, second_reference_input_p_i,
                   first_reference_input_n_i, first_reference_input_p_i};

  for (genvar i = 0; i < 4; i++) begin : g_pin
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        sync_q[i] <= 3'h0;
        filt_q[i] <= 1'b0;
      end else begin
        sync_q[i] <= {sync_q[i][1:0], pin_in[i]};
        if (sync_q[i][1] == sync_q[i][2]) begin
          filt_q[i] <= sync_q[i][2];
        end
      end
    end
  end

  for (genvar r = 0; r < 2; r++) begin : g_ref
    logic [1:0] fam;
    assign fam = reg_q[`CDC_SLOT_REF_FAMILY][2 * r + 1 -: 2];
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        ref_out_q[r] <= 1'b0;
      end else if (reg_q[`CDC_SLOT_REF_POWER][r]) begin
        ref_out_q[r] <= 1'b0;
      end else if (fam != `CDC_FAM_DIFF) begin
        ref_out_q[r] <= filt_q[2 * r];
      end else if (filt_q[2 * r] != filt_q[2 * r + 1]) begin
        ref_out_q[r] <= filt_q[2 * r];
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      deep_q <= 1'b0;
    end else begin
      deep_q <= &reg_q[`CDC_SLOT_REF_POWER][1:0];
    end
  end

  assign first_reference_input_o  = ref_out_q[0];
  assign second_reference_input_o = ref_out_q[1];
  assign ref_power_off_o          = reg_q[`CDC_SLOT_REF_POWER][1:0];
  assign ref_deep_sleep_o         = deep_q;
  assign ref_family_o             = reg_q[`CDC_SLOT_REF_FAMILY][3:0];

  // ratio check helper for channel zero: ticks since the last toggle
  logic [10:0] h_cnt_q;
  logic        h_ok_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      h_cnt_q <= 11'h000;
      h_ok_q  <= 1'b0;
    end else if (ch_state_q[0] != clock_distribution_config_pkg::CH_RUN || sync_pulse_i
                 || wr_en) begin
      h_cnt_q <= 11'h000;
      h_ok_q  <= 1'b0;
    end else if (ch_tick[0] && cnt_q[0] >= div_val[0]) begin
      h_cnt_q <= 11'h000;
      h_ok_q  <= 1'b1;
    end else if (ch_tick[0]) begin
      h_cnt_q <= h_cnt_q + 11'h001;
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !ack_q;
  endsequence
  sequence s_ack_pulse;
    ack_q ##1 !ack_q;
  endsequence

  property p_bus_answer;
    s_req |=> s_ack_pulse;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus ack not one cycle after request");

  property p_reserved_read;
    (s_req and (hit[4] == 1'b0)) |=> (ack_q && dat_q == 32'h0000_0000);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("unmapped read not zero");

  property p_divide;
    (h_ok_q && ch_state_q[0] == clock_distribution_config_pkg::CH_RUN && !ch_off[0]
     && !sync_pulse_i && !wr_en && ch_tick[0] && cnt_q[0] >= div_val[0])
      |-> (h_cnt_q == {1'b0, div_val[0]}) ##1 (chan_clk_q[0] != $past(chan_clk_q[0]));
  endproperty
  a_divide: assert property (p_divide) else $error("channel zero ratio wrong");

  property p_power_off;
    (ch_off[0] && !wr_en) [*2] |-> (ch_state_q[0] == clock_distribution_config_pkg::CH_OFF
                                    && !chan_clk_q[0]);
  endproperty
  a_power_off: assert property (p_power_off) else $error("channel zero not stopped");

  property p_hold;
    (ch_state_q[1] == clock_distribution_config_pkg::CH_HOLD && !ch_mask[1] && !ch_off[1]
     && !sync_pulse_i) |=> (ch_state_q[1] == clock_distribution_config_pkg::CH_HOLD
                            && !chan_clk_q[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("channel one left hold without sync");

  property p_presel;
    (ch_state_q[0] == clock_distribution_config_pkg::CH_RUN && !ch_off[0] && !sync_pulse_i
     && reg_q[`CDC_SLOT_CH0_CTRL][`CDC_CTRL_PRESEL_BIT] && !second_prescaling_divider_tick_i)
      |=> $stable(cnt_q[0]);
  endproperty
  a_presel: assert property (p_presel) else $error("wrong prescaler drove channel zero");

  property p_phase;
    (ch_state_q[0] != clock_distribution_config_pkg::CH_OFF && !ch_off[0] && !ch_mask[0]
     && sync_pulse_i) |=> (cnt_q[0] == ($past(g_chan[0].ph_rem[9:0])));
  endproperty
  a_phase: assert property (p_phase) else $error("sync phase not loaded");

  property p_disabled;
    !reg_q[`CDC_SLOT_OUT_TWO][`CDC_EN_BIT] |=> (p_oe_b_q && n_oe_b_q && !p_q && !n_q);
  endproperty
  a_disabled: assert property (p_disabled) else $error("second output driven while off");

  property p_cmos_pol;
    (reg_q[`CDC_SLOT_OUT_TWO][`CDC_EN_BIT] && out_fmt == `CDC_FMT_CMOS_BOTH)
      |=> (p_q == ($past(chan_clk_q[1]) ^ $past(reg_q[`CDC_SLOT_OUT_TWO][`CDC_POL_P_BIT])));
  endproperty
  a_cmos_pol: assert property (p_cmos_pol) else $error("cmos polarity wrong");

  property p_diff_pol;
    (reg_q[`CDC_SLOT_OUT_TWO][`CDC_EN_BIT] && out_fmt == `CDC_FMT_LVDS)
      |=> (n_q == !p_q && !p_oe_b_q && !n_oe_b_q);
  endproperty
  a_diff_pol: assert property (p_diff_pol) else $error("polarity leaked outside cmos");

  property p_deep;
    (&reg_q[`CDC_SLOT_REF_POWER][1:0]) |=> deep_q ##0 !ref_out_q[0];
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep missing");

  property p_cmos_ref;
    (reg_q[`CDC_SLOT_REF_FAMILY][3:2] != `CDC_FAM_DIFF && !reg_q[`CDC_SLOT_REF_POWER][1])
      |=> (ref_out_q[1] == $past(filt_q[2]));
  endproperty
  a_cmos_ref: assert property (p_cmos_ref) else $error("cmos reference used wrong pin");

endmodule : clock_distribution_config

// ### verification/testbench.sv
// self-checking bench for the clock distribution configuration bank
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0]  wb_sel_i = 4'h0, ref_family_o;
  logic        tick_a = 1'b0, tick_b = 1'b0, sync_p = 1'b0;
  logic [1:0]  chan_clk_o, chan_power_off_o, ref_power_off_o;
  logic        leg_p, leg_n, oe_p_b, oe_n_b, boost, ra_o, rb_o, deep;
  logic [2:0]  fmt;
  logic        ra_p = 1'b0, ra_n = 1'b1, rb_p = 1'b0, rb_n = 1'b1;
  logic [7:0]  rd;
  int          mismatches = 0, tests_run = 0, gap_n, k0;
  clock_distribution_config dut_u (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o),
    .first_prescaling_divider_tick_i(tick_a), .second_prescaling_divider_tick_i(tick_b),
    .sync_pulse_i(sync_p), .chan_clk_o(chan_clk_o), .chan_power_off_o(chan_power_off_o),
    .second_output_pair_p_o(leg_p), .second_output_pair_n_o(leg_n),
    .second_output_pair_p_oe_b_o(oe_p_b), .second_output_pair_n_oe_b_o(oe_n_b),
    .second_output_pair_boost_o(boost), .second_output_pair_format_o(fmt),
    .first_reference_input_p_i(ra_p), .first_reference_input_n_i(ra_n),
    .second_reference_input_p_i(rb_p), .second_reference_input_n_i(rb_n),
    .first_reference_input_o(ra_o), .second_reference_input_o(rb_o),
    .ref_power_off_o(ref_power_off_o), .ref_deep_sleep_o(deep), .ref_family_o(ref_family_o));
  always #50 core_clk_i = ~core_clk_i;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task test_done;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : test_done
  task bail;
    mismatches++;
    test_done();
  endtask : bail
  // one classic cycle; request held until the edge at which ack is sampled high
  task wb(input logic we, input logic [11:0] idx, input logic [7:0] d);
    int n;
    @(posedge core_clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {18'h0, idx, 2'h0};
    wb_dat_i <= {24'h0, d};
    wb_sel_i <= 4'hF;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) bail();
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb
  task wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : wait_n
  task pulse;
    @(posedge core_clk_i);
    sync_p <= 1'b1;
    @(posedge core_clk_i);
    sync_p <= 1'b0;
  endtask : pulse
  // cycles between two successive toggles of a channel output
  task gap(input int ch);
    logic v;
    int   k;
    k = 0;
    @(negedge core_clk_i);
    v = chan_clk_o[ch];
    while (chan_clk_o[ch] === v && k < 3000) begin
      @(negedge core_clk_i);
      k++;
    end
    v = chan_clk_o[ch];
    gap_n = 0;
    while (chan_clk_o[ch] === v && gap_n < 3000) begin
      @(negedge core_clk_i);
      gap_n++;
    end
    if (k >= 3000 || gap_n >= 3000) bail();
  endtask : gap
  task lag(input logic [7:0] ph);
    wb(1'b1, 12'h504, ph);
    pulse();
    gap_n = 0;
    do begin
      @(negedge core_clk_i);
      gap_n++;
    end while (chan_clk_o[0] !== 1'b1 && gap_n < 100);
    if (chan_clk_o[0] !== 1'b1) bail();
  endtask : lag
  task t_regs;
    logic [11:0] ia [6];
    logic [7:0]  ea [6];
    ia = '{12'h503, 12'h504, 12'h601, 12'h506, 12'h7FF, 12'h509};
    ea = '{8'h0F, 8'h3F, 8'h0F, 8'h00, 8'h00, 8'h3F};
    chk({oe_p_b, oe_n_b, fmt, boost, chan_clk_o}, {2'h3, 3'h1, 1'b0, 2'h0});
    wb(1'b0, 12'h505, 8'h00);
    chk(rd, 8'h10);
    wb(1'b0, 12'h600, 8'h00);
    chk(rd, 8'h00);
    for (int i = 0; i < 6; i++) begin
      wb(1'b1, ia[i], 8'hFF);
      wb(1'b0, ia[i], 8'h00);
      chk(rd, ea[i]);
      wb(1'b1, ia[i], 8'h00);
    end
    $display("register test done");
  endtask : t_regs
  task t_div;
    wb(1'b1, 12'h502, 8'h02);
    @(posedge core_clk_i);
    tick_a <= 1'b1;
    wait_n(20);
    chk(chan_clk_o[0], 1'b0);
    pulse();
    gap(0);
    chk(gap_n, 3);
    wb(1'b1, 12'h503, 8'h01);
    wb(1'b1, 12'h502, 8'h00);
    pulse();
    gap(0);
    chk(gap_n, 257);
    wb(1'b1, 12'h503, 8'h00);
    wb(1'b1, 12'h502, 8'h03);
    lag(8'h00);
    k0 = gap_n;
    lag(8'h02);
    chk(k0 - gap_n, 2);
    wb(1'b1, 12'h503, 8'h08);
    wait_n(2);
    chk({chan_power_off_o[0], chan_clk_o[0]}, 2'h2);
    wb(1'b1, 12'h503, 8'h00);
    wb(1'b1, 12'h508, 8'h04);
    wb(1'b1, 12'h507, 8'h00);
    wb(1'b1, 12'h500, 8'h20);
    wait_n(10);
    chk(chan_clk_o[1], 1'b0);
    @(posedge core_clk_i);
    tick_b <= 1'b1;
    gap(1);
    chk(gap_n, 1);
    $display("divider test done");
  endtask : t_div
  task t_out;
    logic [15:0] oe_tab;
    oe_tab = 16'hE4C3;
    for (int f = 0; f < 8; f++) begin
      wb(1'b1, 12'h505, {1'b0, f[2:0], 4'h3});
      wait_n(3);
      chk({oe_p_b, oe_n_b, fmt, boost}, {oe_tab[2*f +: 2], f[2:0], 1'b1});
    end
    wb(1'b1, 12'h505, 8'h10);
    wait_n(3);
    chk({oe_p_b, oe_n_b}, 2'h3);
    wb(1'b1, 12'h505, 8'h45);
    wait_n(3);
    chk(leg_p ^ leg_n, 1'b0);
    wb(1'b1, 12'h505, 8'h15);
    wait_n(3);
    chk(leg_p ^ leg_n, 1'b1);
    $display("output test done");
  endtask : t_out
  task t_ref;
    @(posedge core_clk_i);
    ra_p <= 1'b1;
    wait_n(10);
    chk(ra_o, 1'b0);
    wb(1'b1, 12'h601, 8'h01);
    wait_n(8);
    chk({ra_o, ref_family_o}, 5'h11);
    wb(1'b1, 12'h601, 8'h0D);
    @(posedge core_clk_i);
    rb_p <= 1'b1;
    wait_n(8);
    chk(rb_o, 1'b1);
    wb(1'b1, 12'h600, 8'h01);
    wait_n(4);
    chk({ra_o, rb_o, ref_power_off_o, deep}, 5'h0A);
    wb(1'b1, 12'h600, 8'h03);
    wait_n(4);
    chk({rb_o, deep}, 2'h1);
    $display("reference test done");
  endtask : t_ref
  initial begin
    repeat (60000) @(posedge core_clk_i);
    bail();
  end
  initial begin
    repeat (3) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_regs();
    t_div();
    t_out();
    t_ref();
    test_done();
  end
endmodule : testbench
